// >>> shared/dbgp_pkg.sv
package dbgp_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [15:0] CTRL_ADDR = 16'h0000;
  localparam logic [15:0] IND_ADDR_ADDR = 16'h0004;
  localparam logic [15:0] IND_DATA_ADDR = 16'h0008;
  localparam logic [15:0] STATUS_ADDR = 16'h000C;
  localparam logic [15:0] LIDRV_ADDR = 16'h4F80;
  localparam logic [7:0] LIDRV_PAGE = 8'h4E;
  localparam logic [7:0] LIDRV_REG = 8'h80;
  localparam int CTRL_EN_BIT = 0;
  localparam int GP_A_BIT = 2;
  localparam int GP_B_BIT = 3;
  localparam logic [7:0] LIDRV_RESET = 8'h00;
  localparam logic [15:0] IND_RESET = 16'h0000;

  typedef struct packed {
    logic [3:0] upper;
    logic gp_output_b_bit;
    logic gp_output_a_bit;
    logic [1:0] lower;
  } dbgp_lidrv_t;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] reg_index;
  } dbgp_ind_t;
endpackage

// >>> hdl/dbgp_pin_share.sv
`timescale 1ns/100ps
`default_nettype none
module dbgp_pin_share
  import dbgp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  input wire logic drop_bus_clock_ch3,
  input wire logic [7:0] drop_word_in,
  output logic [7:0] drop_bus_data_ch3
);
  logic [2:0] clk_sync_ff;
  logic clk_rise;
  logic clk_lvl_ff;
  logic bus_en_ff;
  dbgp_lidrv_t lidrv_ff;
  dbgp_ind_t ind_ff;
  logic [7:0] drop_word_ff;
  logic setup_ph;
  logic access_wr;
  logic [DATA_W-1:0] nxt_prdata;
  logic nxt_err;
  logic [DATA_W-1:0] prdata_ff;
  logic pslverr_ff;

  function automatic logic is_lidrv(input logic [ADDR_W-1:0] a,
                                    input dbgp_ind_t ia);
    is_lidrv = (a == LIDRV_ADDR) ||
               ((a == IND_DATA_ADDR) && (ia.page == LIDRV_PAGE) &&
                (ia.reg_index == LIDRV_REG));
  endfunction

  assign setup_ph = psel && !penable;
  assign access_wr = psel && penable && pwrite && !pslverr_ff;
  assign pready = psel && penable;
  assign prdata = prdata_ff;
  assign pslverr = pready && pslverr_ff;

  // link clock is foreign: three stages, a level counts once 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_sync_ff <= 3'h0;
    else
      clk_sync_ff <= {clk_sync_ff[1:0], drop_bus_clock_ch3};
  end

  // filtered level; reset low matches the idle link so no false edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_lvl_ff <= 1'b0;
    else if (clk_sync_ff[1] == clk_sync_ff[2])
      clk_lvl_ff <= clk_sync_ff[2];
  end
  assign clk_rise = clk_sync_ff[1] && clk_sync_ff[2] && !clk_lvl_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drop_word_ff <= 8'h00;
    else if (bus_en_ff && clk_rise)
      drop_word_ff <= drop_word_in;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_en_ff <= 1'b0;
    else if (access_wr && paddr == CTRL_ADDR && pstrb[0])
      bus_en_ff <= pwdata[CTRL_EN_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ind_ff <= IND_RESET;
    else if (access_wr && paddr == IND_ADDR_ADDR)
    begin
      if (pstrb[0])
        ind_ff.reg_index <= pwdata[7:0];
      if (pstrb[1])
        ind_ff.page <= pwdata[15:8];
    end
  end

  // stored regardless of bus enable; only the pin mux hides it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lidrv_ff <= LIDRV_RESET;
    else if (access_wr && pstrb[0] && is_lidrv(paddr, ind_ff))
      lidrv_ff <= pwdata[7:0];
  end

  always_comb
  begin
    nxt_prdata = '0;
    nxt_err = 1'b0;
    if (is_lidrv(paddr, ind_ff))
      nxt_prdata = {24'h000000, lidrv_ff};
    else if (paddr == CTRL_ADDR)
      nxt_prdata = {31'h00000000, bus_en_ff};
    else if (paddr == IND_ADDR_ADDR)
      nxt_prdata = {16'h0000, ind_ff};
    else if (paddr == STATUS_ADDR)
      nxt_prdata = {22'h000000, clk_sync_ff[2], bus_en_ff, drop_word_ff};
    else
      nxt_err = 1'b1;
  end

  // answer prepared in setup so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
      pslverr_ff <= nxt_err;
    end
  end

  always_comb
  begin
    drop_bus_data_ch3 = drop_word_ff;
    if (!bus_en_ff)
    begin
      drop_bus_data_ch3[0] = lidrv_ff.gp_output_a_bit;
      drop_bus_data_ch3[1] = lidrv_ff.gp_output_b_bit;
    end
  end

  sequence s_ind_sel;
    ind_ff.page == LIDRV_PAGE && ind_ff.reg_index == LIDRV_REG;
  endsequence
  sequence s_ind_wr;
    s_ind_sel ##0 (access_wr && pstrb[0] && paddr == IND_DATA_ADDR);
  endsequence

  property p_sel_en;
    @(posedge pclk) disable iff (!presetn)
    bus_en_ff |-> drop_bus_data_ch3 == drop_word_ff;
  endproperty
  a_sel_en: assert property (p_sel_en)
    else $error("enabled pins do not carry drop data");

  property p_only_on_rise;
    @(posedge pclk) disable iff (!presetn)
    !(bus_en_ff && clk_rise) |=> $stable(drop_word_ff);
  endproperty
  a_only_on_rise: assert property (p_only_on_rise)
    else $error("drop data moved without clock rise");

  property p_word_capture;
    @(posedge pclk) disable iff (!presetn)
    (bus_en_ff && clk_rise) |=> drop_word_ff == $past(drop_word_in);
  endproperty
  a_word_capture: assert property (p_word_capture)
    else $error("drop word not captured whole");

  property p_gp_a;
    @(posedge pclk) disable iff (!presetn)
    !bus_en_ff |-> drop_bus_data_ch3[0] == lidrv_ff[GP_A_BIT];
  endproperty
  a_gp_a: assert property (p_gp_a)
    else $error("pin 0 not following drive bit 2");

  property p_gp_b;
    @(posedge pclk) disable iff (!presetn)
    !bus_en_ff |-> drop_bus_data_ch3[1] == lidrv_ff[GP_B_BIT];
  endproperty
  a_gp_b: assert property (p_gp_b)
    else $error("pin 1 not following drive bit 3");

  property p_indirect;
    @(posedge pclk) disable iff (!presetn)
    s_ind_wr |=> lidrv_ff == $past(pwdata[7:0]);
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("indirect write missed drive register");

  property p_direct_mirror;
    @(posedge pclk) disable iff (!presetn)
    (access_wr && pstrb[0] && paddr == LIDRV_ADDR && !bus_en_ff
     && !(setup_ph && psel))
    |=> drop_bus_data_ch3[1:0] == $past(pwdata[GP_B_BIT:GP_A_BIT])
        || bus_en_ff;
  endproperty
  a_direct_mirror: assert property (p_direct_mirror)
    else $error("general outputs do not mirror written value");

  property p_hidden_while_en;
    @(posedge pclk) disable iff (!presetn)
    (bus_en_ff && access_wr && paddr == LIDRV_ADDR && !clk_rise)
    |=> $stable(drop_bus_data_ch3) ##0 lidrv_ff == $past(pwdata[7:0]);
  endproperty
  a_hidden_while_en: assert property (p_hidden_while_en)
    else $error("drive write leaked to pins or was lost");
endmodule
`default_nettype wire

// >>> test/dbgp_sink.sv
`timescale 1ns/100ps
`default_nettype none
// far side takes each byte on the link rise after it is launched
module dbgp_sink
(
  input wire logic link_clk,
  input wire logic [7:0] pins,
  output logic [7:0] byte_q
);
  always_ff @(posedge link_clk)
  begin
    byte_q <= pins;
  end
endmodule
`default_nettype wire

// >>> test/test_drop_bus_gpo_pin_share.sv
`timescale 1ns/100ps
`default_nettype none
module test_drop_bus_gpo_pin_share;
  import dbgp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lclk, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] word, pins, got;
  int err_count, checks_done, cyc;
  dbgp_pin_share dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .drop_bus_clock_ch3(lclk), .drop_word_in(word),
    .drop_bus_data_ch3(pins));
  dbgp_sink sink_u (.link_clk(lclk), .pins(pins), .byte_q(got));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic end_sim;
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the access edge's register updates settle before callers look
    @(posedge pclk);
  endtask
  // one 80 ns link clock period, held low between bytes
  task automatic lk(input logic [7:0] w);
    word <= w;
    repeat (10) @(posedge pclk);
    lclk <= 1'b1;
    repeat (10) @(posedge pclk);
    lclk <= 1'b0;
  endtask
  task automatic t_gp;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, LIDRV_ADDR, {24'h0, 4'hF, i[1:0], 2'h3});
      chk("gp pins", {24'h0, pins}, {30'h0, i[1:0]});
      apb(1'b0, LIDRV_ADDR, 32'h0);
      chk("drive rd", rd, {24'h0, 4'hF, i[1:0], 2'h3});
    end
  endtask
  task automatic t_ind;
    apb(1'b1, IND_ADDR_ADDR, 32'h00004E80);
    apb(1'b1, IND_DATA_ADDR, 32'h00000008);
    apb(1'b0, LIDRV_ADDR, 32'h0);
    chk("ind wr", rd, 32'h8);
    chk("ind pin", {24'h0, pins}, 32'h2);
    apb(1'b0, IND_DATA_ADDR, 32'h0);
    chk("ind rd", rd, 32'h8);
    chk("ind err", {31'h0, er}, 32'h0);
    apb(1'b0, 16'h0100, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
  endtask
  task automatic t_bus;
    apb(1'b1, CTRL_ADDR, 32'h1);
    lk(8'hA5);
    chk("drop", {24'h0, pins}, 32'hA5);
    word <= 8'h5A;
    repeat (20) @(posedge pclk);
    chk("hold", {24'h0, pins}, 32'hA5);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status", rd, 32'h000001A5);
    apb(1'b1, LIDRV_ADDR, 32'h0C);
    chk("en wr", {24'h0, pins}, 32'hA5);
    apb(1'b0, LIDRV_ADDR, 32'h0);
    chk("en rd", rd, 32'h0C);
    lk(8'h3C);
    chk("drop2", {24'h0, pins}, 32'h3C);
    chk("sink", {24'h0, got}, 32'hA5);
    apb(1'b1, CTRL_ADDR, 32'h0);
    chk("dis", {30'h0, pins[1:0]}, 32'h3);
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, lclk} = 5'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    word = 8'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, LIDRV_ADDR, 32'h0);
    chk("rst", rd, {24'h0, LIDRV_RESET});
    t_gp();
    t_ind();
    t_bus();
    end_sim();
  end
endmodule
`default_nettype wire
